// file: logic/flog_pkg.sv
// Purpose: constants for the flash block state logger
// Assumes: 10 MHz mclk_in, two 1 KB data flash blocks
// Notes: flash offsets are byte addresses inside the log region
// How it works
// - flash seen as 1 KB blocks, first two bytes are valid and invalid flags
// - both flags reading FF means the block is unused
// - valid flag programmed to 00 before records go into a block
// - at block end the invalid flag is programmed to 00
// - after invalidating, find an unused block and erase it before use
// - flags FF/FF unused, 00/FF valid, 00/00 invalid
// - newest record found by blank checks in 2-byte steps from the end
// - next write slot is the one just after the newest record
// - newest record in last slot forces block change, write at first slot
// - only blank checks decide writability, never program a written location
// - no valid block at startup: erase block 0 and use it as valid
// - no record: target first indicator, remaining count zero
// - record byte: target in upper nibble, count 0 to 10 in lower nibble
// - target blinks every 500 ms until count ends; a press starts 10 blinks
// - presses ignored while blinking; accepted press swaps the target
// - low voltage: save record, light save-done indicator, then stop
// - a 00 terminator byte follows the saved record byte
// - any flash error lights both blink indicators and stops
// - key taken on falling edges, disabled during setup, indicators start off
// - save address computed after restore so saving only programs
// - key press valid only if still held about 10 ms later
// - exactly two flash blocks hold the log
package flog_pkg;
   // -------------------------------------------------
   // flash layout
   // -------------------------------------------------
   localparam int ADDR_W = 11;
   localparam int BLOCK_COUNT = 2;
   localparam logic [9:0] VFLAG_OFS = 10'h000;
   localparam logic [9:0] IFLAG_OFS = 10'h001;
   localparam logic [9:0] FIRST_SLOT = 10'h002;
   localparam logic [9:0] LAST_SLOT = 10'h3FE;
   localparam logic [9:0] SLOT_STEP = 10'h002;
   localparam logic [7:0] FLAG_SET = 8'h00;
   localparam logic [7:0] FLAG_BLANK = 8'hFF;
   localparam logic [7:0] TERM_BYTE = 8'h00;
   localparam logic [1:0] CMD_READ = 2'h0;
   localparam logic [1:0] CMD_PROG = 2'h1;
   localparam logic [1:0] CMD_ERASE = 2'h2;
   localparam logic [1:0] CMD_BLANK = 2'h3;
   // -------------------------------------------------
   // record and blinking
   // -------------------------------------------------
   localparam logic [3:0] TGT_FIRST = 4'h0;
   localparam logic [3:0] TGT_SECOND = 4'h1;
   localparam logic [3:0] MAX_COUNT = 4'hA;
   localparam logic [3:0] PRESS_BLINKS = 4'hA;
   // -------------------------------------------------
   // timing
   // -------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int BLINK_MS = 500;
   localparam int DEBOUNCE_MS = 10;
   localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
   localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int CNT_W = 24;
   // -------------------------------------------------
   // registers
   // -------------------------------------------------
   localparam logic [3:0] STATUS_OFS = 4'h0;
   localparam logic [3:0] CONTROL_OFS = 4'h4;
   localparam int ST_COUNT_LSB = 0;
   localparam int ST_TARGET_BIT = 4;
   localparam int ST_STOP_BIT = 5;
   localparam int ST_FAULT_BIT = 6;
   localparam int ST_SAVED_BIT = 7;
   localparam int ST_WADDR_LSB = 8;
   localparam int CT_KEY_EN_BIT = 0;
   localparam int CT_SAVE_BIT = 1;
   localparam logic [1:0] CONTROL_RESET = 2'h1;
endpackage : flog_pkg

// file: logic/key_qualifier.sv
// Purpose: falling edge key detection with hold check
// Assumes: key input already synchronous, active low
// Notes: one press pulse per qualified edge
module key_qualifier #(
   parameter int HOLD_CYCLES = flog_pkg::DEBOUNCE_CYCLES
) (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic user_key_n_in,
   input wire logic arm_in,
   output logic press_out
);
   typedef struct packed {
      logic prev;
      logic busy;
      logic press;
      logic [flog_pkg::CNT_W-1:0] cnt;
   } kq_t;
   kq_t q;
   kq_t next_q;

   always_comb begin
      next_q = q;
      next_q.prev = user_key_n_in;
      next_q.press = 1'b0;
      if (q.busy) begin
         next_q.cnt = q.cnt + 1'b1;
         if (q.cnt == flog_pkg::CNT_W'(HOLD_CYCLES - 1)) begin
            next_q.busy = 1'b0;
            next_q.press = ~user_key_n_in & arm_in;
         end
      end else if (q.prev & ~user_key_n_in & arm_in) begin
         next_q.busy = 1'b1;
         next_q.cnt = '0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         q <= '{prev: 1'b1, busy: 1'b0, press: 1'b0, cnt: '0};
      end else begin
         q <= next_q;
      end
   end

   assign press_out = q.press;

   chk_press_held: assert property (@(posedge mclk_in) disable iff (reset_in)
      press_out |-> $past(q.busy) && !$past(user_key_n_in))
      else $error("press without held key");
endmodule : key_qualifier

// file: logic/flash_block_state_logger.sv
// Purpose: blink state log kept in two data flash blocks
// Assumes: flash answers each request with one done pulse
// Notes: stops in save or fault state until reset
//
// Register access over Avalon-MM and the address map were left to the implementer.
module flash_block_state_logger #(
   parameter int BLINK_CYCLES = flog_pkg::BLINK_CYCLES,
   parameter int DEBOUNCE_CYCLES = flog_pkg::DEBOUNCE_CYCLES
) (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic user_key_n_in,
   input wire logic low_voltage_detector_in,
   output logic first_indicator_out,
   output logic second_indicator_out,
   output logic save_done_indicator_out,
   output logic fl_req_out,
   output logic [1:0] fl_cmd_out,
   output logic [flog_pkg::ADDR_W-1:0] fl_addr_out,
   output logic [7:0] fl_wdata_out,
   input wire logic fl_done_in,
   input wire logic fl_err_in,
   input wire logic [7:0] fl_rdata_in,
   input wire logic fl_blank_in,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out
);
   typedef enum logic [4:0] {
      ST_BOOT, ST_RD_V, ST_RD_I, ST_ERASE_INIT, ST_MARK_INIT,
      ST_BLANK, ST_READ, ST_CHG_INVAL, ST_CHG_RD_V, ST_CHG_RD_I,
      ST_CHG_ERASE, ST_CHG_MARK, ST_RUN, ST_SAVE_REC, ST_SAVE_TERM,
      ST_SAVED, ST_FAULT
   } state_t;

   typedef struct packed {
      state_t state;
      logic req;
      logic [1:0] cmd;
      logic [flog_pkg::ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic blk;
      logic [9:0] slot;
      logic [9:0] wr_slot;
      logic [7:0] vflag;
      logic target;
      logic [3:0] count;
      logic lamp;
      logic [flog_pkg::CNT_W-1:0] tick;
      logic [1:0] ctrl;
      logic ack;
      logic [31:0] rdata;
      logic ind0;
      logic ind1;
      logic ind3;
   } st_t;

   st_t s;
   st_t next_s;
   logic key_press;
   logic is_op;
   logic done_ok;
   logic [1:0] op_cmd;
   logic [flog_pkg::ADDR_W-1:0] op_addr;
   logic [7:0] op_wdata;
   logic [31:0] status_word;

   // -------------------------------------------------
   // key input
   // -------------------------------------------------
   key_qualifier #(.HOLD_CYCLES(DEBOUNCE_CYCLES)) u_key (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .user_key_n_in(user_key_n_in),
      .arm_in(s.state == ST_RUN && s.ctrl[flog_pkg::CT_KEY_EN_BIT]),
      .press_out(key_press)
   );

   // -------------------------------------------------
   // flash operation per state
   // -------------------------------------------------
   always_comb begin
      is_op = 1'b1;
      op_cmd = flog_pkg::CMD_READ;
      op_wdata = flog_pkg::FLAG_SET;
      op_addr = {s.blk, s.slot};
      case (s.state)
         ST_RD_V: op_addr = {s.blk, flog_pkg::VFLAG_OFS};
         ST_RD_I: op_addr = {s.blk, flog_pkg::IFLAG_OFS};
         ST_ERASE_INIT: begin
            op_cmd = flog_pkg::CMD_ERASE;
            op_addr = '0;
         end
         ST_MARK_INIT: begin
            op_cmd = flog_pkg::CMD_PROG;
            op_addr = {1'b0, flog_pkg::VFLAG_OFS};
         end
         ST_BLANK: op_cmd = flog_pkg::CMD_BLANK;
         ST_READ: op_cmd = flog_pkg::CMD_READ;
         ST_CHG_INVAL: begin
            op_cmd = flog_pkg::CMD_PROG;
            op_addr = {s.blk, flog_pkg::IFLAG_OFS};
         end
         ST_CHG_RD_V: op_addr = {~s.blk, flog_pkg::VFLAG_OFS};
         ST_CHG_RD_I: op_addr = {~s.blk, flog_pkg::IFLAG_OFS};
         ST_CHG_ERASE: begin
            op_cmd = flog_pkg::CMD_ERASE;
            op_addr = {~s.blk, 10'h000};
         end
         ST_CHG_MARK: begin
            op_cmd = flog_pkg::CMD_PROG;
            op_addr = {~s.blk, flog_pkg::VFLAG_OFS};
         end
         ST_SAVE_REC: begin
            op_cmd = flog_pkg::CMD_PROG;
            op_addr = {s.blk, s.wr_slot};
            op_wdata = {3'h0, s.target, s.count};
         end
         ST_SAVE_TERM: begin
            op_cmd = flog_pkg::CMD_PROG;
            op_addr = {s.blk, s.wr_slot | 10'h001};
            op_wdata = flog_pkg::TERM_BYTE;
         end
         default: is_op = 1'b0;
      endcase
   end

   assign done_ok = s.req & fl_done_in & ~fl_err_in;

   // -------------------------------------------------
   // main sequencer
   // -------------------------------------------------
   always_comb begin
      next_s = s;
      if (is_op && !s.req) begin
         next_s.req = 1'b1;
         next_s.cmd = op_cmd;
         next_s.addr = op_addr;
         next_s.wdata = op_wdata;
      end else if (s.req && (fl_done_in || fl_err_in)) begin
         next_s.req = 1'b0;
      end
      case (s.state)
         ST_BOOT: begin
            next_s.blk = 1'b0;
            next_s.state = ST_RD_V;
         end
         ST_RD_V: if (done_ok) begin
            next_s.vflag = fl_rdata_in;
            next_s.state = ST_RD_I;
         end
         ST_RD_I: if (done_ok) begin
            if (s.vflag == flog_pkg::FLAG_SET && fl_rdata_in == flog_pkg::FLAG_BLANK) begin
               next_s.slot = flog_pkg::LAST_SLOT;
               next_s.state = ST_BLANK;
            end else if (s.blk == 1'(flog_pkg::BLOCK_COUNT - 1)) begin
               next_s.blk = 1'b0;
               next_s.state = ST_ERASE_INIT;
            end else begin
               next_s.blk = s.blk + 1'b1;
               next_s.state = ST_RD_V;
            end
         end
         ST_ERASE_INIT: if (done_ok) begin
            next_s.state = ST_MARK_INIT;
         end
         ST_MARK_INIT: if (done_ok) begin
            next_s.target = 1'b0;
            next_s.count = 4'h0;
            next_s.wr_slot = flog_pkg::FIRST_SLOT;
            next_s.state = ST_RUN;
         end
         ST_BLANK: if (done_ok) begin
            if (!fl_blank_in) begin
               next_s.state = ST_READ;
            end else if (s.slot == flog_pkg::FIRST_SLOT) begin
               next_s.target = 1'b0;
               next_s.count = 4'h0;
               next_s.wr_slot = flog_pkg::FIRST_SLOT;
               next_s.state = ST_RUN;
            end else begin
               next_s.slot = s.slot - flog_pkg::SLOT_STEP;
            end
         end
         ST_READ: if (done_ok) begin
            // out of range reads as no record
            if (fl_rdata_in[7:4] <= flog_pkg::TGT_SECOND && fl_rdata_in[3:0] <= flog_pkg::MAX_COUNT) begin
               next_s.target = fl_rdata_in[4];
               next_s.count = fl_rdata_in[3:0];
            end else begin
               next_s.target = 1'b0;
               next_s.count = 4'h0;
            end
            if (s.slot == flog_pkg::LAST_SLOT) begin
               next_s.state = ST_CHG_INVAL;
            end else begin
               // slot after newest, ready before save
               next_s.wr_slot = s.slot + flog_pkg::SLOT_STEP;
               next_s.state = ST_RUN;
            end
         end
         ST_CHG_INVAL: if (done_ok) begin
            next_s.state = ST_CHG_RD_V;
         end
         ST_CHG_RD_V: if (done_ok) begin
            next_s.vflag = fl_rdata_in;
            next_s.state = ST_CHG_RD_I;
         end
         // other block must not be valid
         ST_CHG_RD_I: if (done_ok) begin
            if (s.vflag == flog_pkg::FLAG_SET && fl_rdata_in == flog_pkg::FLAG_BLANK) begin
               next_s.state = ST_FAULT;
            end else begin
               next_s.state = ST_CHG_ERASE;
            end
         end
         ST_CHG_ERASE: if (done_ok) begin
            next_s.state = ST_CHG_MARK;
         end
         ST_CHG_MARK: if (done_ok) begin
            next_s.blk = ~s.blk;
            next_s.wr_slot = flog_pkg::FIRST_SLOT;
            next_s.state = ST_RUN;
         end
         ST_RUN: begin
            if (low_voltage_detector_in || s.ctrl[flog_pkg::CT_SAVE_BIT]) begin
               next_s.lamp = 1'b0;
               next_s.state = ST_SAVE_REC;
            end else if (s.count != 4'h0) begin
               next_s.tick = s.tick + 1'b1;
               if (s.tick == flog_pkg::CNT_W'(BLINK_CYCLES - 1)) begin
                  next_s.tick = '0;
                  next_s.lamp = ~s.lamp;
                  if (s.lamp) begin
                     next_s.count = s.count - 1'b1;
                  end
               end
            end else if (key_press) begin
               next_s.target = ~s.target;
               next_s.count = flog_pkg::PRESS_BLINKS;
               next_s.lamp = 1'b1;
               next_s.tick = '0;
            end else begin
               next_s.lamp = 1'b0;
            end
         end
         ST_SAVE_REC: if (done_ok) begin
            next_s.state = ST_SAVE_TERM;
         end
         ST_SAVE_TERM: if (done_ok) begin
            next_s.state = ST_SAVED;
         end
         ST_SAVED: next_s.state = ST_SAVED;
         ST_FAULT: next_s.state = ST_FAULT;
         default: next_s.state = ST_FAULT;
      endcase
      if (s.req && fl_err_in) begin
         next_s.state = ST_FAULT;
      end
      // software side, one wait state per access
      next_s.ack = (avs_read_in | avs_write_in) & ~s.ack;
      if (avs_read_in && !s.ack) begin
         next_s.rdata = (avs_address_in == flog_pkg::STATUS_OFS) ? status_word :
                        (avs_address_in == flog_pkg::CONTROL_OFS) ? {30'h0, s.ctrl} : 32'h0;
      end
      if (avs_write_in && s.ack && avs_address_in == flog_pkg::CONTROL_OFS) begin
         next_s.ctrl = avs_writedata_in[1:0];
      end
      next_s.ind0 = (next_s.state == ST_RUN && next_s.lamp && !next_s.target) || next_s.state == ST_FAULT;
      next_s.ind1 = (next_s.state == ST_RUN && next_s.lamp && next_s.target) || next_s.state == ST_FAULT;
      next_s.ind3 = next_s.state == ST_SAVED;
   end

   always_comb begin
      status_word = 32'h0;
      status_word[flog_pkg::ST_COUNT_LSB +: 4] = s.count;
      status_word[flog_pkg::ST_TARGET_BIT] = s.target;
      status_word[flog_pkg::ST_STOP_BIT] = s.state == ST_SAVED || s.state == ST_FAULT;
      status_word[flog_pkg::ST_FAULT_BIT] = s.state == ST_FAULT;
      status_word[flog_pkg::ST_SAVED_BIT] = s.state == ST_SAVED;
      status_word[flog_pkg::ST_WADDR_LSB +: flog_pkg::ADDR_W] = {s.blk, s.wr_slot};
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         s <= '{state: ST_BOOT, ctrl: flog_pkg::CONTROL_RESET, default: '0};
      end else begin
         s <= next_s;
      end
   end

   // -------------------------------------------------
   // outputs
   // -------------------------------------------------
   assign fl_req_out = s.req;
   assign fl_cmd_out = s.cmd;
   assign fl_addr_out = s.addr;
   assign fl_wdata_out = s.wdata;
   assign first_indicator_out = s.ind0;
   assign second_indicator_out = s.ind1;
   assign save_done_indicator_out = s.ind3;
   assign avs_readdata_out = s.rdata;
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~s.ack;

   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   chk_req_held: assert property (s.req && !fl_done_in && !fl_err_in |=> s.req && $stable(s.addr))
      else $error("flash request dropped early");
   chk_gap_after_done: assert property (s.req && fl_done_in |=> !s.req)
      else $error("flash request without gap");
   chk_flag_zero: assert property (s.req && s.cmd == flog_pkg::CMD_PROG && s.addr[9:1] == 9'h000
      |-> s.wdata == flog_pkg::FLAG_SET)
      else $error("flag programmed non zero");
   chk_term_byte: assert property (s.state == ST_SAVE_TERM && s.req |-> s.wdata == flog_pkg::TERM_BYTE
      && s.addr[0])
      else $error("terminator wrong");
   chk_fault_lamps: assert property (s.req && fl_err_in |=> ##1 s.ind0 && s.ind1)
      else $error("fault lamps off");
   chk_save_lamp: assert property (s.state == ST_SAVE_TERM && done_ok |=> ##1 s.ind3 && !s.ind0)
      else $error("save lamp missing");
   chk_count_range: assert property (s.count <= flog_pkg::MAX_COUNT)
      else $error("count out of range");
   chk_busy_key: assert property (s.state == ST_RUN && s.count != 4'h0 && key_press
      |=> $stable(s.target))
      else $error("press taken while blinking");
   chk_scan_step: assert property (s.state == ST_BLANK && done_ok && fl_blank_in
      && s.slot != flog_pkg::FIRST_SLOT |=> s.slot == $past(s.slot) - flog_pkg::SLOT_STEP)
      else $error("scan step wrong");
endmodule : flash_block_state_logger

// file: tb/flash_model.sv
// Purpose: behavioural data flash answering the logger's request port
// Assumes: 2 KB array, two 1 KB blocks, contents kept across logger reset
// Notes: answer delay drawn at random, 0 to 3 cycles; err_next_in forces errors
module flash_model (
   input wire logic mclk_in,
   input wire logic req_in,
   input wire logic [1:0] cmd_in,
   input wire logic [10:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic err_next_in,
   output logic done_out,
   output logic err_out,
   output logic [7:0] rdata_out,
   output logic blank_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:2047];
   int wait_c = 0;
   int ovw_cnt = 0;
   initial begin
      done_out = 1'b0;
      err_out = 1'b0;
      rdata_out = 8'h00;
      blank_out = 1'b0;
   end
   // -------------------------------------------------
   // request handling
   // -------------------------------------------------
   always @(posedge mclk_in) begin
      done_out <= 1'b0;
      err_out <= 1'b0;
      // outside an answer the data lines toggle so a stale value never passes
      rdata_out <= ~rdata_out;
      blank_out <= ~blank_out;
      if (req_in && !done_out && !err_out) begin
         if (wait_c > 0) begin
            wait_c <= wait_c - 1;
         end else begin
            wait_c <= $urandom_range(0, 3);
            if (err_next_in) begin
               err_out <= 1'b1;
            end else begin
               done_out <= 1'b1;
               case (cmd_in)
                  2'h0: rdata_out <= mem[addr_in];
                  2'h1: begin
                     if (mem[addr_in] !== 8'hFF) ovw_cnt <= ovw_cnt + 1;
                     mem[addr_in] <= mem[addr_in] & wdata_in;
                  end
                  2'h2: for (int i = 0; i < 1024; i++) mem[{addr_in[10], i[9:0]}] <= 8'hFF;
                  default: blank_out <= (mem[addr_in] == 8'hFF) && (mem[addr_in | 11'h001] == 8'hFF);
               endcase
            end
         end
      end
   end
endmodule : flash_model

// file: tb/flash_block_state_logger_tb_top.sv
// Purpose: self-checking bench for the flash block state logger
// Assumes: shortened blink and debounce counts, flash model kept across resets
// Notes: random record slots and values from a fixed seed
module flash_block_state_logger_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BLINK = 20;
   logic mclk_in = 1'b0;
   logic reset_in = 1'b1;
   logic key_n = 1'b1;
   logic lv = 1'b0;
   logic err_next = 1'b0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [3:0] avs_addr = 4'h0;
   logic [31:0] avs_wdata = 32'h0;
   logic [31:0] avs_rd;
   logic [31:0] q;
   logic avs_wait;
   logic lamp0, lamp1, lamp2, req, done, err, blank;
   logic [1:0] cmd;
   logic [10:0] addr;
   logic [7:0] wd, rd, r;
   logic [10:0] s;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   always #50 mclk_in = ~mclk_in;
   flash_block_state_logger #(.BLINK_CYCLES(BLINK), .DEBOUNCE_CYCLES(5)) i_flash_block_state_logger (
      .mclk_in(mclk_in), .reset_in(reset_in), .user_key_n_in(key_n), .low_voltage_detector_in(lv),
      .first_indicator_out(lamp0), .second_indicator_out(lamp1), .save_done_indicator_out(lamp2),
      .fl_req_out(req), .fl_cmd_out(cmd), .fl_addr_out(addr), .fl_wdata_out(wd), .fl_done_in(done),
      .fl_err_in(err), .fl_rdata_in(rd), .fl_blank_in(blank), .avs_address_in(avs_addr),
      .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_wdata),
      .avs_readdata_out(avs_rd), .avs_waitrequest_out(avs_wait));
   flash_model i_flash_model (.mclk_in(mclk_in), .req_in(req), .cmd_in(cmd), .addr_in(addr), .wdata_in(wd),
      .err_next_in(err_next), .done_out(done), .err_out(err), .rdata_out(rd), .blank_out(blank));
   // -------------------------------------------------
   // helpers
   // -------------------------------------------------
   function automatic logic [31:0] rec_st(input logic [7:0] rec, input logic [10:0] w);
      return {13'h0, w, 3'h0, rec[4], rec[3:0]};
   endfunction : rec_st
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      avs_read <= !wr;
      avs_write <= wr;
      avs_addr <= a;
      avs_wdata <= d;
      @(posedge mclk_in);
      while (avs_wait !== 1'b0) @(posedge mclk_in);
      q = avs_rd;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic idle_wait();
      int n;
      n = 0;
      while (n < 30) begin
         @(posedge mclk_in);
         n = req ? 0 : n + 1;
      end
   endtask : idle_wait
   task automatic boot();
      reset_in <= 1'b1;
      repeat (12) @(posedge mclk_in);
      reset_in <= 1'b0;
      idle_wait();
   endtask : boot
   task automatic press(input int hold);
      @(posedge mclk_in);
      key_n <= 1'b0;
      repeat (hold) @(posedge mclk_in);
      key_n <= 1'b1;
      repeat (3) @(posedge mclk_in);
   endtask : press
   task automatic preset(input logic [10:0] slot, input logic [7:0] rec);
      for (int i = 0; i < 2048; i++) i_flash_model.mem[i] = 8'hFF;
      if (slot != 11'h0) begin
         i_flash_model.mem[0] = 8'h00;
         i_flash_model.mem[slot] = rec;
         i_flash_model.mem[slot + 1] = 8'h00;
      end
   endtask : preset
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   // hang guard, well above the longest expected run
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         end_sim();
      end
   end
   // -------------------------------------------------
   // main sequence
   // -------------------------------------------------
   initial begin
      void'($urandom(10541));
      preset(11'h0, 8'h00);
      boot();
      chk({16'h0, i_flash_model.mem[0], i_flash_model.mem[1]}, 32'h000000FF);
      bus(1'b0, 4'h0, 32'h0);
      chk(q & 32'h0007FF1F, rec_st(8'h00, 11'h002));
      chk({lamp0, lamp1, lamp2}, 32'h0);
      bus(1'b0, 4'h4, 32'h0);
      chk(q, 32'h00000001);
      bus(1'b0, 4'h8, 32'h0);
      chk(q, 32'h0);
      $display("test boot empty done");
      bus(1'b1, 4'h4, 32'h0);
      press(10);
      bus(1'b1, 4'h4, 32'h1);
      press(2);
      bus(1'b0, 4'h0, 32'h0);
      chk(q & 32'h1F, 32'h0);
      press(10);
      @(negedge mclk_in);
      chk({lamp0, lamp1}, 32'h1);
      bus(1'b0, 4'h0, 32'h0);
      chk(q & 32'h1F, 32'h1A);
      press(10);
      bus(1'b0, 4'h0, 32'h0);
      chk(q[4], 1'b1);
      repeat (BLINK * 2 * 10 + 60) @(posedge mclk_in);
      bus(1'b0, 4'h0, 32'h0);
      chk({lamp0, lamp1, 3'h0, q[4:0]}, 32'h10);
      $display("test key done");
      lv <= 1'b1;
      idle_wait();
      chk({i_flash_model.mem[2], i_flash_model.mem[3]}, 32'h1000);
      bus(1'b0, 4'h0, 32'h0);
      chk({lamp2, q[7], q[5]}, 32'h7);
      lv <= 1'b0;
      boot();
      bus(1'b0, 4'h0, 32'h0);
      chk(q & 32'h0007FF1F, rec_st(8'h10, 11'h004));
      $display("test save restore done");
      for (int k = 0; k < 3; k++) begin
         // last two slots left out, the last one forces a block change
         s = 11'h002 + 11'(2 * $urandom_range(0, 508));
         r = {3'h0, 1'($urandom_range(0, 1)), 4'($urandom_range(0, 10))};
         preset(s, r);
         boot();
         bus(1'b0, 4'h0, 32'h0);
         chk(q & 32'h0007FF1F, rec_st(r, s + 11'h002));
      end
      $display("test random restore done");
      r = 8'h07;
      preset(11'h3FE, r);
      i_flash_model.mem[11'h500] = 8'h55;
      boot();
      chk({i_flash_model.mem[1], i_flash_model.mem[11'h400], i_flash_model.mem[11'h401]}, 32'h0000FF);
      chk(i_flash_model.mem[11'h500], 8'hFF);
      bus(1'b0, 4'h0, 32'h0);
      chk(q & 32'h0007FF1F, rec_st(r, 11'h402));
      $display("test block change done");
      err_next <= 1'b1;
      boot();
      bus(1'b0, 4'h0, 32'h0);
      chk({lamp0, lamp1, q[6], q[5]}, 32'hF);
      chk(i_flash_model.ovw_cnt, 32'h0);
      $display("test fault done");
      end_sim();
   end
endmodule : flash_block_state_logger_tb_top
